// ### core/gsl_pkg.sv
package gsl_pkg;
   // link formats; gray steps along unchannelised -> T1 -> E1
   typedef enum logic [1:0]
   {
      GSL_UNCH = 2'b00,
      GSL_T1 = 2'b01,
      GSL_E1 = 2'b11
   } gsl_mode_e;

   // clock and framing gap detection
   localparam int CLK_NS = 20;
   localparam int GAP_NS = 1000;
   // least time, so round up
   localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int IDLE_W = 16;

   // octet and slot layout
   localparam int OCT_W = 8;
   localparam int FIFO_DEPTH = 16;
   localparam int SLOT_W = 5;
   localparam int SLOT_NUM = 32;
   localparam logic [2:0] BIT_FIRST = 3'h0;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [4:0] SLOT_FIRST = 5'h01;
   localparam logic [4:0] T1_LAST = 5'h18;
   localparam logic [4:0] E1_LAST = 5'h1f;

   // values after reset
   localparam logic [7:0] OCT_RST = 8'h00;
   localparam logic SLOT_PROVISIONED_FLAG_RST = 1'b0;
   localparam logic LINE_RST = 1'b1;
endpackage

// ### core/gsl_sync2.sv
`timescale 1ns/1ps
module gsl_sync2
(
   // clocking
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   // level in and out
   input wire logic din,
   output logic dout
);
   logic meta_ff;

   // the first stage feeds only the second
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         meta_ff <= 1'b0;
         dout <= 1'b0;
      end
      else if (en)
      begin
         meta_ff <= din;
         dout <= meta_ff;
      end
   end
endmodule

// ### core/gsl_fifo.sv
`timescale 1ns/1ps
module gsl_fifo
#(
   parameter int W = 8,
   parameter int DEPTH = 16
)
(
   // clocking
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   // fill side
   input wire logic [W-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   // drain side
   output logic [W-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);

   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr_ff;
   logic [AW-1:0] rdPtr_ff;
   logic [AW:0] count_ff;
   logic [AW:0] nxt_count;
   wire push = en && inValid && inReady;
   // output register refills when empty or being drained
   wire pop = en && (count_ff != '0) && (!outValid || outReady);

   // ready is registered off the next count so it never lies
   assign nxt_count = count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

   always_ff @(posedge clk)
   begin
      if (push)
      begin
         mem[wrPtr_ff] <= inData;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wrPtr_ff <= '0;
         rdPtr_ff <= '0;
         count_ff <= '0;
         inReady <= 1'b1;
         outValid <= 1'b0;
         outData <= '0;
      end
      else if (en)
      begin
         count_ff <= nxt_count;
         inReady <= (nxt_count != DEPTH[AW:0]);
         if (push)
            wrPtr_ff <= wrPtr_ff + 1'b1;
         if (pop)
         begin
            rdPtr_ff <= rdPtr_ff + 1'b1;
            outData <= mem[rdPtr_ff];
            outValid <= 1'b1;
         end
         else if (outReady)
            outValid <= 1'b0;
      end
   end
endmodule

// ### core/gsl_link_port.sv
`timescale 1ns/1ps
// What this block does
// (R1) receive bits are taken only on rising edges of the receive link clock
// (R2) unchannelised receive packs eight taken bits per octet, first bit as MSB
// (R3) far end may stop the receive clock anywhere to skip bits
// (R4) T1 receive: first bit after gap is slot 1 MSB, last is slot 24 LSB
// (R5) T1 receive clock runs continuously, gapped only over the framing bit
// (R6) E1 receive: first bit after gap is slot 1 MSB, last is slot 31 LSB
// (R7) E1 receive clock runs continuously, gapped only over the framing byte
// (R8) channelised receive drops slots whose provisioned flag is low
// (R9) transmit data changes only on falling tx clock edges, MSB first
// (R10) unchannelised transmit holds the bit while clock idles, resumes after
// (R11) far end may stop the transmit clock anywhere
// (R12) T1 transmit sends slots 1 to 24, slot 24 LSB just before gap
// (R13) T1 transmit clock runs continuously, gapped only over the framing bit
// (R14) E1 transmit sends slots 1 to 31, slot 31 LSB just before gap
// (R15) E1 transmit clock runs continuously, gapped only over the framing byte
// (R16) channelised transmit sends idle fill in unprovisioned slots
// (R17) mode selects format; slot count restarts at first bit after a gap
module gsl_link_port
#(
   parameter int GAP_CYCLES = gsl_pkg::GAP_CYC
)
(
   // system clocking
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   // link setup
   input wire gsl_pkg::gsl_mode_e linkMode,
   input wire logic [7:0] idleFill,
   // slot provisioning writes
   input wire logic provWrEn,
   input wire logic provWrTx,
   input wire logic [4:0] provWrSlot,
   input wire logic provWrFlag,
   // transmit octets from user
   input wire logic [7:0] txOctet,
   input wire logic txOctetValid,
   output logic txOctetReady,
   // receive octets to user
   output logic [7:0] rxOctet_ff,
   output logic [4:0] rxOctetSlot_ff,
   output logic rxOctetValid_ff,
   // receive link pins
   input wire logic rxLinkClock,
   input wire logic rxLinkData,
   // transmit link pins
   input wire logic txLinkClock,
   output logic txLinkData_ff
);
   // link-domain state
   logic rxRstMeta_ff;
   logic txRstMeta_ff;
   logic rxRstLink;
   logic txRstLink;
   logic rxBitTog_ff;
   logic rxBitData_ff;
   logic txTakeTog_ff;
   // system-domain state
   logic [1:0] togSync;
   logic [1:0] togDly_ff;
   logic [1:0] evt;
   logic [gsl_pkg::IDLE_W-1:0] idle_ff [2];
   logic [1:0] gap_ff;
   logic [31:0] rxProv_ff;
   logic [31:0] txProv_ff;
   logic [2:0] rxIdx_ff;
   logic [4:0] rxSlot_ff;
   logic [7:0] rxShift_ff;
   logic [2:0] txIdx_ff;
   logic [4:0] txSlot_ff;
   logic [7:0] txOct_ff;
   logic txNextBit_ff;
   logic [7:0] fifoData;
   logic fifoValid;
   logic txPop;

   // reset reaches each link domain through two flops of its own clock;
   // a stopped link clock therefore keeps its domain in reset until two edges pass
   always_ff @(posedge rxLinkClock)
   begin
      rxRstMeta_ff <= rst_n;
      rxRstLink <= rxRstMeta_ff;
   end

   always_ff @(posedge txLinkClock)
   begin
      txRstMeta_ff <= rst_n;
      txRstLink <= txRstMeta_ff;
   end

   // receive bit capture; a gapped clock simply yields no bit
   always_ff @(posedge rxLinkClock)
   begin
      if (!rxRstLink)
         rxBitTog_ff <= 1'b0;
      else
      begin
         rxBitTog_ff <= ~rxBitTog_ff; // [R1]
         rxBitData_ff <= rxLinkData; // [R1]
      end
   end

   // transmit launch on the falling edge; next bit is held stable by handshake
   always_ff @(negedge txLinkClock)
   begin
      if (!txRstLink)
      begin
         txTakeTog_ff <= 1'b0;
         txLinkData_ff <= gsl_pkg::LINE_RST;
      end
      else
      begin
         txTakeTog_ff <= ~txTakeTog_ff;
         txLinkData_ff <= txNextBit_ff; // [R9] [R10]
      end
   end

   // per direction: toggle crossing, event detect, idle timer marking a gap
   for (genvar d = 0; d < 2; d++)
   begin : g_dir
      gsl_sync2 u_tog (.clk(clk_sys), .rst_n(rst_n), .en(clkEn),
         .din(d == 0 ? rxBitTog_ff : txTakeTog_ff), .dout(togSync[d]));
      assign evt[d] = clkEn && (togSync[d] ^ togDly_ff[d]);
      always_ff @(posedge clk_sys)
      begin
         if (!rst_n)
         begin
            togDly_ff[d] <= 1'b0;
            idle_ff[d] <= '0;
            gap_ff[d] <= 1'b0;
         end
         else if (clkEn)
         begin
            togDly_ff[d] <= togSync[d];
            if (evt[d])
            begin
               idle_ff[d] <= '0;
               gap_ff[d] <= 1'b0;
            end
            else if (idle_ff[d] == gsl_pkg::IDLE_W'(GAP_CYCLES - 1))
               gap_ff[d] <= 1'b1; // [R17]
            else if (!gap_ff[d])
               idle_ff[d] <= idle_ff[d] + 1'b1;
         end
      end
   end

   // provisioning flags, one per slot and direction
   for (genvar s = 0; s < gsl_pkg::SLOT_NUM; s++)
   begin : g_slot_provisioned_flag
      always_ff @(posedge clk_sys)
      begin
         if (!rst_n)
         begin
            rxProv_ff[s] <= gsl_pkg::SLOT_PROVISIONED_FLAG_RST;
            txProv_ff[s] <= gsl_pkg::SLOT_PROVISIONED_FLAG_RST;
         end
         else if (clkEn && provWrEn && provWrSlot == 5'(s))
         begin
            if (provWrTx)
               txProv_ff[s] <= provWrFlag;
            else
               rxProv_ff[s] <= provWrFlag;
         end
      end
   end

   // mode decode
   wire isChan = (linkMode != gsl_pkg::GSL_UNCH);
   wire [4:0] lastSlot = (linkMode == gsl_pkg::GSL_T1) ? gsl_pkg::T1_LAST
      : gsl_pkg::E1_LAST;

   // receive framing; a bit after a gap opens slot 1 in channelised modes
   wire rxEvt = evt[0];
   wire rxRestart = isChan && gap_ff[0]; // [R4] [R6] [R17]
   wire [2:0] rxCurIdx = rxRestart ? gsl_pkg::BIT_FIRST : rxIdx_ff;
   wire [4:0] rxCurSlot = rxRestart ? gsl_pkg::SLOT_FIRST : rxSlot_ff;
   wire [7:0] rxNewShift = {rxShift_ff[6:0], rxBitData_ff}; // [R2]
   wire rxDone = rxEvt && (rxCurIdx == gsl_pkg::BIT_LAST);
   wire rxKeep = !isChan || rxProv_ff[rxCurSlot]; // [R8]
   wire [4:0] rxNxtSlot = (rxCurSlot == lastSlot) ? gsl_pkg::SLOT_FIRST
      : rxCurSlot + 5'h01;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         rxIdx_ff <= gsl_pkg::BIT_FIRST;
         rxSlot_ff <= gsl_pkg::SLOT_FIRST;
         rxShift_ff <= gsl_pkg::OCT_RST;
         rxOctet_ff <= gsl_pkg::OCT_RST;
         rxOctetSlot_ff <= gsl_pkg::SLOT_FIRST;
         rxOctetValid_ff <= 1'b0;
      end
      else if (clkEn)
      begin
         rxOctetValid_ff <= rxDone && rxKeep; // [R8]
         if (rxEvt)
         begin
            rxShift_ff <= rxNewShift;
            rxIdx_ff <= rxCurIdx + 3'h1; // [R2]
            rxSlot_ff <= (rxCurIdx == gsl_pkg::BIT_LAST) ? rxNxtSlot : rxCurSlot;
         end
         if (rxDone)
         begin
            rxOctet_ff <= rxNewShift;
            rxOctetSlot_ff <= rxCurSlot; // [R4] [R6]
         end
      end
   end

   // transmit octet buffer; user is stalled through txOctetReady
   gsl_fifo #(.W(gsl_pkg::OCT_W), .DEPTH(gsl_pkg::FIFO_DEPTH)) u_txFifo (
      .clk(clk_sys), .rst_n(rst_n), .en(clkEn),
      .inData(txOctet), .inValid(txOctetValid), .inReady(txOctetReady),
      .outData(fifoData), .outValid(fifoValid), .outReady(txPop));

   // transmit sequencing: prepare the next bit after each falling edge taken
   wire txAdv = evt[1];
   wire txAtStart = (txIdx_ff == gsl_pkg::BIT_FIRST) && (txSlot_ff == gsl_pkg::SLOT_FIRST);
   // realign to slot 1 if a gap arrives mid-frame; drops the partial octet
   wire txResync = clkEn && isChan && gap_ff[1] && !txAtStart && !txAdv; // [R17]
   wire txLoad = (txAdv && txIdx_ff == gsl_pkg::BIT_LAST) || txResync;
   wire [4:0] txLoadSlot = (txResync || txSlot_ff == lastSlot) ? gsl_pkg::SLOT_FIRST
      : txSlot_ff + 5'h01; // [R12] [R14]
   wire txUseFifo = !isChan || txProv_ff[txLoadSlot];
   assign txPop = txLoad && txUseFifo && fifoValid;
   // underrun and unprovisioned slots both send idle fill
   wire [7:0] txNewOct = txPop ? fifoData : idleFill; // [R16]
   wire [2:0] txNxtIdx = txIdx_ff + 3'h1;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         txIdx_ff <= gsl_pkg::BIT_FIRST;
         txSlot_ff <= gsl_pkg::SLOT_FIRST;
         txOct_ff <= gsl_pkg::OCT_RST;
         txNextBit_ff <= gsl_pkg::OCT_RST[7];
      end
      else if (txLoad)
      begin
         txIdx_ff <= gsl_pkg::BIT_FIRST;
         txSlot_ff <= txLoadSlot;
         txOct_ff <= txNewOct;
         txNextBit_ff <= txNewOct[7]; // [R9]
      end
      else if (txAdv)
      begin
         txIdx_ff <= txNxtIdx;
         txNextBit_ff <= txOct_ff[gsl_pkg::BIT_LAST - txNxtIdx]; // [R9]
      end
   end

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_rx_only_on_edge;
      rxOctetValid_ff |-> $past(rxEvt);
   endproperty
   a_rx_only_on_edge: assert property (p_rx_only_on_edge) else $error("octet with no edge"); // [R1]

   property p_rx_msb_first;
      rxOctetValid_ff |-> (rxOctet_ff == rxShift_ff) && (rxOctet_ff[0] == $past(rxBitData_ff));
   endproperty
   a_rx_msb_first: assert property (p_rx_msb_first) else $error("octet bit order"); // [R2]

   property p_rx_restart;
      (rxEvt && clkEn && isChan && gap_ff[0]) |=> (rxIdx_ff == 3'h1) && (rxSlot_ff == 5'h01);
   endproperty
   a_rx_restart: assert property (p_rx_restart) else $error("no slot 1 after gap"); // [R4]

   property p_rx_t1_range;
      (rxOctetValid_ff && linkMode == gsl_pkg::GSL_T1) |-> rxOctetSlot_ff inside {[1:24]};
   endproperty
   a_rx_t1_range: assert property (p_rx_t1_range) else $error("T1 slot out of range"); // [R4]

   property p_rx_e1_range;
      (rxOctetValid_ff && linkMode == gsl_pkg::GSL_E1) |-> rxOctetSlot_ff inside {[1:31]};
   endproperty
   a_rx_e1_range: assert property (p_rx_e1_range) else $error("E1 slot out of range"); // [R6]

   property p_rx_slot_provisioned_flag;
      (rxOctetValid_ff && isChan)
         |-> ((($past(rxProv_ff) >> rxOctetSlot_ff) & 32'h0000_0001) != 32'h0000_0000);
   endproperty
   a_rx_slot_provisioned_flag: assert property (p_rx_slot_provisioned_flag) else $error("unprovisioned slot passed"); // [R8]

   property p_tx_msb;
      (txAdv && !txResync && txIdx_ff == 3'h7)
         |=> (txIdx_ff == 3'h0) && (txNextBit_ff == txOct_ff[7]);
   endproperty
   a_tx_msb: assert property (p_tx_msb) else $error("octet not started at MSB"); // [R9]

   property p_tx_hold;
      (clkEn && !txAdv && !txResync) |=> $stable(txNextBit_ff);
   endproperty
   a_tx_hold: assert property (p_tx_hold) else $error("bit changed while clock idle"); // [R10]

   property p_tx_t1_wrap;
      (txAdv && linkMode == gsl_pkg::GSL_T1 && txSlot_ff == 5'h18 && txIdx_ff == 3'h7)
         |=> txSlot_ff == 5'h01;
   endproperty
   a_tx_t1_wrap: assert property (p_tx_t1_wrap) else $error("T1 wrap after slot 24"); // [R12]

   property p_tx_e1_wrap;
      (txAdv && linkMode == gsl_pkg::GSL_E1 && txSlot_ff == 5'h1f && txIdx_ff == 3'h7)
         |=> txSlot_ff == 5'h01;
   endproperty
   a_tx_e1_wrap: assert property (p_tx_e1_wrap) else $error("E1 wrap after slot 31"); // [R14]

   property p_tx_idle;
      (txLoad && isChan && !txProv_ff[txLoadSlot]) |=> txOct_ff == $past(idleFill);
   endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("idle fill not sent"); // [R16]

   c_rx_t1_octet: cover property (rxOctetValid_ff && linkMode == gsl_pkg::GSL_T1);
   c_rx_e1_last: cover property (rxOctetValid_ff && rxOctetSlot_ff == 5'h1f);
   c_tx_resync: cover property (txResync);
   c_tx_full: cover property (!txOctetReady);
endmodule

// ### test/gsl_line_model.sv
`timescale 1ns/1ps
module gsl_line_model
(
   // receive pins toward the port
   output logic rxLinkClock,
   output logic rxLinkData,
   // transmit pins
   output logic txLinkClock,
   input wire logic txLinkData
);
   // half of the 125 ns link period, no phase tie to the system clock
   localparam realtime HALF = 62.5;
   logic txSeen[$];

   // clocks rest high between frames
   initial
   begin
      rxLinkClock = 1'b1;
      rxLinkData = 1'b1;
      txLinkClock = 1'b1;
   end

   // one bit; a stretched low phase skips time without a rising edge
   task automatic rxBit(input logic b, input int stretchNs);
      rxLinkData = ~b;
      rxLinkClock = 1'b0;
      #(stretchNs);
      rxLinkData = b;
      #(HALF); // full rate inside frames
      rxLinkClock = 1'b1;
      #(HALF);
   endtask

   // quiescent high; data keeps moving so no stale value is seen
   task automatic rxGap(input int periods);
      repeat (2 * periods)
      begin
         #(HALF);
         rxLinkData = ~rxLinkData;
      end
   endtask

   // one transmit bit, taken on the rising edge
   task automatic txBit(input int stretchNs);
      txLinkClock = 1'b0;
      #(HALF + stretchNs);
      txLinkClock = 1'b1;
      txSeen.push_back(txLinkData);
      #(HALF);
   endtask

   // stretch the high phase of the last bit
   task automatic txGap(input int periods);
      #(2 * HALF * periods);
   endtask
endmodule

// ### test/test_gapped_serial_link_port.sv
`timescale 1ns/1ps
module test_gapped_serial_link_port;
   logic clk_sys;
   logic rst_n;
   logic clkEn;
   gsl_pkg::gsl_mode_e linkMode;
   logic [7:0] idleFill;
   logic provWrEn;
   logic provWrTx;
   logic [4:0] provWrSlot;
   logic provWrFlag;
   logic [7:0] txOctet;
   logic txOctetValid;
   logic txOctetReady;
   logic [7:0] rxOctet;
   logic [4:0] rxSlot;
   logic rxValid;
   logic rxLinkClock;
   logic rxLinkData;
   logic txLinkClock;
   logic txLinkData;
   int failures = 0;
   int n_tests = 0;
   int cycles = 0;
   logic [7:0] rxQ[$];
   logic [4:0] slotQ[$];
   logic provRx[32];

   // short gap limit so 3 idle link periods count as a framing gap
   gsl_link_port #(.GAP_CYCLES(9)) u_dut
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .linkMode(linkMode),
      .idleFill(idleFill),
      .provWrEn(provWrEn),
      .provWrTx(provWrTx),
      .provWrSlot(provWrSlot),
      .provWrFlag(provWrFlag),
      .txOctet(txOctet),
      .txOctetValid(txOctetValid),
      .txOctetReady(txOctetReady),
      .rxOctet_ff(rxOctet),
      .rxOctetSlot_ff(rxSlot),
      .rxOctetValid_ff(rxValid),
      .rxLinkClock(rxLinkClock),
      .rxLinkData(rxLinkData),
      .txLinkClock(txLinkClock),
      .txLinkData_ff(txLinkData)
   );

   gsl_line_model u_line
   (
      .rxLinkClock(rxLinkClock),
      .rxLinkData(rxLinkData),
      .txLinkClock(txLinkClock),
      .txLinkData(txLinkData)
   );

   initial
   begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // collect octets mid-cycle, away from the launching edge
   always @(negedge clk_sys)
   begin
      cycles++;
      if (rxValid === 1'b1)
      begin
         rxQ.push_back(rxOctet);
         slotQ.push_back(rxSlot);
      end
      if (cycles == 30000)
      begin
         failures++;
         $display("[FAIL] run length expected below 30000 seen %0d", cycles);
         end_sim();
      end
   end

   // transmit data may only move while the link clock is low
   always @(txLinkData)
      if (rst_n === 1'b1)
         check("clock at tx change", 8'h00, {7'h0, txLinkClock});

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic slot_provisioned_flag(input logic tx, input int slot, input logic flag);
      @(negedge clk_sys);
      provWrEn = 1'b1;
      provWrTx = tx;
      provWrSlot = slot[4:0];
      provWrFlag = flag;
      @(negedge clk_sys);
      provWrEn = 1'b0;
      if (!tx)
         provRx[slot] = flag;
   endtask

   task automatic setMode(input gsl_pkg::gsl_mode_e m);
      @(negedge clk_sys);
      linkMode = m;
   endtask

   task automatic sendOctet(input logic [7:0] v);
      for (int i = 7; i >= 0; i--)
         u_line.rxBit(v[i], 0);
   endtask

   function automatic int found(input logic want[$], input logic got[$]);
      for (int i = 0; i + want.size() <= got.size(); i++)
      begin
         int j;
         j = 0;
         while (j < want.size() && got[i + j] === want[j])
            j++;
         if (j == want.size())
            return 1;
      end
      return 0;
   endfunction

   // stalls low and high at odd places must not disturb octet packing
   task automatic test_unch_rx();
      logic [7:0] pat[3];
      pat = '{8'ha5, 8'h3c, 8'h81};
      setMode(gsl_pkg::GSL_UNCH);
      rxQ.delete();
      for (int k = 0; k < 24; k++)
      begin
         u_line.rxBit(pat[k / 8][7 - k % 8], (k % 3 == 1) ? 300 : 0);
         if (k % 5 == 2)
            u_line.rxGap(2);
      end
      repeat (20) @(negedge clk_sys);
      check("unch rx count", 8'h03, 8'(rxQ.size()));
      for (int i = 0; i < 3; i++)
         check("unch rx octet", pat[i], rxQ[i]);
      $display("test unchannelised receive done");
   endtask

   // with the enable low the system side is frozen: a write, a push and link bits are lost
   task automatic test_freeze();
      @(negedge clk_sys);
      clkEn = 1'b0;
      rxQ.delete();
      txOctet = 8'h55;
      txOctetValid = 1'b1;
      slot_provisioned_flag(1'b0, 2, 1'b1);
      provRx[2] = 1'b0;
      txOctetValid = 1'b0;
      sendOctet(8'h5a);
      repeat (5) @(negedge clk_sys);
      clkEn = 1'b1;
      repeat (20) @(negedge clk_sys);
      check("frozen rx count", 8'h00, 8'(rxQ.size()));
      $display("test clock enable freeze done");
   endtask

   // two frames; only provisioned slots come out, tagged with their number
   task automatic test_chan_rx(input gsl_pkg::gsl_mode_e m, input int last);
      int k;
      setMode(m);
      u_line.rxGap(3);
      rxQ.delete();
      slotQ.delete();
      repeat (2)
      begin
         for (int s = 1; s <= last; s++)
            sendOctet(8'ha0 ^ 8'(s));
         u_line.rxGap(3);
      end
      k = 0;
      repeat (2)
         for (int s = 1; s <= last; s++)
            if (provRx[s])
            begin
               check("rx slot", 8'(s), {3'h0, slotQ[k]});
               check("rx slot data", 8'ha0 ^ 8'(s), rxQ[k]);
               k++;
            end
      check("rx count", 8'(k), 8'(rxQ.size()));
      $display("test channelised receive done");
   endtask

   // fill with the link stopped, then drain through a stalling clock
   task automatic test_unch_tx();
      int n;
      logic want[$];
      setMode(gsl_pkg::GSL_UNCH);
      idleFill = 8'hff;
      n = 0;
      txOctet = 8'h10;
      txOctetValid = 1'b1;
      while (txOctetReady === 1'b1 && n < 40)
      begin
         @(negedge clk_sys);
         n++;
         txOctet = 8'h10 + 8'(n);
      end
      check("fifo capacity", 8'h11, 8'(n));
      txOctet = 8'hee;
      repeat (5) @(negedge clk_sys);
      txOctetValid = 1'b0;
      u_line.txSeen.delete();
      for (int k = 0; k < 176; k++)
      begin
         u_line.txBit((k % 5 == 3) ? 200 : 0);
         if (k % 7 == 4)
            u_line.txGap(3);
      end
      check("ready after drain", 8'h01, {7'h0, txOctetReady});
      for (int i = 0; i <= n; i++)
         for (int b = 7; b >= 0; b--)
            want.push_back((i < n) ? (8'h10 + 8'(i)) >> b : 8'h01);
      check("tx stream", 8'h01, 8'(found(want, u_line.txSeen)));
      $display("test unchannelised transmit done");
   endtask

   // one octet queued: first frame carries it, the rest is idle fill
   task automatic test_chan_tx(input gsl_pkg::gsl_mode_e m, input int last, input int pslot);
      logic [7:0] got;
      logic [7:0] exp;
      setMode(m);
      idleFill = 8'h0f;
      slot_provisioned_flag(1'b1, pslot, 1'b1);
      txOctet = 8'h96;
      txOctetValid = 1'b1;
      @(negedge clk_sys);
      txOctetValid = 1'b0;
      u_line.txGap(3);
      for (int f = 0; f < 2; f++)
      begin
         u_line.txSeen.delete();
         repeat (8 * last) u_line.txBit(0);
         u_line.txGap(3);
         for (int s = 1; s <= last; s++)
         begin
            for (int b = 0; b < 8; b++)
               got[7 - b] = u_line.txSeen[8 * (s - 1) + b];
            exp = (s == pslot && f == 0) ? 8'h96 : idleFill;
            check("tx slot data", exp, got);
         end
      end
      slot_provisioned_flag(1'b1, pslot, 1'b0);
      $display("test channelised transmit done");
   endtask

   initial
   begin
      rst_n = 1'b0;
      clkEn = 1'b1;
      linkMode = gsl_pkg::GSL_UNCH;
      idleFill = 8'hff;
      provWrEn = 1'b0;
      provWrTx = 1'b0;
      provWrSlot = 5'h00;
      provWrFlag = 1'b0;
      txOctet = 8'h00;
      txOctetValid = 1'b0;
      foreach (provRx[i])
         provRx[i] = 1'b0;
      // reset is longer than usual: link domains need their own edges in it
      fork
         repeat (5) u_line.rxBit(1'b0, 0);
         repeat (5) u_line.txBit(0);
         repeat (40) @(negedge clk_sys);
      join
      rst_n = 1'b1;
      // link domains leave reset only after two of their own edges; those bits are dropped
      fork
         repeat (2) u_line.rxBit(1'b0, 0);
         repeat (2) u_line.txBit(0);
      join
      test_unch_rx();
      test_freeze();
      slot_provisioned_flag(1'b0, 1, 1'b1);
      slot_provisioned_flag(1'b0, 13, 1'b1);
      slot_provisioned_flag(1'b0, 24, 1'b1);
      test_chan_rx(gsl_pkg::GSL_T1, 24);
      slot_provisioned_flag(1'b0, 13, 1'b0);
      slot_provisioned_flag(1'b0, 31, 1'b1);
      test_chan_rx(gsl_pkg::GSL_E1, 31);
      test_unch_tx();
      test_chan_tx(gsl_pkg::GSL_T1, 24, 24);
      // slot 1 is fetched at the previous wrap, so a late provisioning targets slot 31
      test_chan_tx(gsl_pkg::GSL_E1, 31, 31);
      end_sim();
   end
endmodule
